/* File: spm_shared_pin_port_mux.sv */
// Added by the designer: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module spm_shared_pin_port_mux (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [5:0] bitwise_port_io_bits_i,
	output logic [7:0] bitwise_port_o,
	output logic [7:0] bitwise_port_oe,
	output logic subclk_osc_en,
	input wire logic [11:0] nibble_ports_i,
	output spm_pkg::spm_pio_t nibble_ports_out,
	output logic [11:0] nibble_ports_pullup,
	input wire logic [11:0] lcd_segment_outputs_shared,
	input wire logic [2:0] lcd_segment_outputs_low,
	output logic [2:0] seg_low_o,
	output logic [2:0] seg_low_oe,
	output logic [2:0] lcd_bias_supply_pins_sel,
	input wire logic [3:0] lcd_common_in,
	output logic [3:0] lcd_common_outputs,
	input wire logic timer_io_pin_i,
	output logic timer_io_pin_o,
	output logic timer_io_pin_oe,
	input wire logic timer2_pwm,
	output logic timer1_count_clk,
	output logic ext_int_req,
	output logic key_wakeup,
	input wire logic software_reset_instr,
	input wire logic wdt_reset,
	input wire logic por_reset,
	input wire logic vdrop_reset,
	output logic reset_pin_oe,
	output logic irq
);
	// ========================================
	// state
	spm_pkg::spm_st_t s_q;
	spm_pkg::spm_st_t s_d;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] w,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
			begin
				r[8*i +: 8] = w[8*i +: 8];
			end
		end
		return r;
	endfunction

	logic [31:0] wv;
	logic [2:0] clr;
	logic [2:0] ev;
	logic [11:0] pseg;
	logic wake_lvl;
	logic rst_any;

	// ========================================
	// next state
	always_comb
	begin
		s_d = s_q;
		wv = '0;
		clr = '0;
		// pin inputs through two flops, only stage two is read
		s_d.d_m = bitwise_port_io_bits_i;
		s_d.d_s = s_q.d_m;
		s_d.p_m = nibble_ports_i;
		s_d.p_s = s_q.p_m;
		s_d.c_m = timer_io_pin_i;
		s_d.c_s = s_q.c_m;

		// write channel: address and data taken in either order
		if (s_axi_awvalid && s_q.awready)
		begin
			s_d.awaddr = s_axi_awaddr;
			s_d.aw_have = 1'b1;
			s_d.awready = 1'b0;
		end
		if (s_axi_wvalid && s_q.wready)
		begin
			s_d.wdata = s_axi_wdata;
			s_d.wstrb = s_axi_wstrb;
			s_d.w_have = 1'b1;
			s_d.wready = 1'b0;
		end
		if (s_q.aw_have && s_q.w_have)
		begin
			s_d.aw_have = 1'b0;
			s_d.w_have = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = spm_pkg::RESP_OK;
			case (s_q.awaddr)
				spm_pkg::A_D_LAT:
				begin
					wv = merge(32'(s_q.d_lat), s_q.wdata, s_q.wstrb);
					s_d.d_lat = wv[7:0];
				end
				spm_pkg::A_D_CMOS:
				begin
					wv = merge(32'(s_q.d_cmos), s_q.wdata, s_q.wstrb);
					s_d.d_cmos = wv[5:0];
				end
				spm_pkg::A_SKIP:
				begin
					if (s_q.wstrb[0])
					begin
						s_d.skip_idx = s_q.wdata[2:0];
						// skip when the tested pin reads low; bits 6 and 7 never skip
						s_d.skip = (s_q.wdata[2:0] < 3'(spm_pkg::D_IO_BITS))
							&& !s_q.d_s[s_q.wdata[2:0]];
					end
				end
				spm_pkg::A_P_LAT:
				begin
					wv = merge(32'(s_q.p_lat), s_q.wdata, s_q.wstrb);
					s_d.p_lat = wv[11:0];
				end
				spm_pkg::A_P_CMOS:
				begin
					wv = merge(32'(s_q.p_cmos), s_q.wdata, s_q.wstrb);
					s_d.p_cmos = wv[11:0];
				end
				spm_pkg::A_CFG:
				begin
					wv = merge(32'(s_q.cfg), s_q.wdata, s_q.wstrb);
					s_d.cfg = spm_pkg::spm_cfg_t'(wv[9:0]);
				end
				spm_pkg::A_SEGSEL:
				begin
					wv = merge(32'(s_q.segsel), s_q.wdata, s_q.wstrb);
					s_d.segsel = wv[11:0];
				end
				spm_pkg::A_LCD:
				begin
					wv = merge(32'({s_q.bias_en, s_q.duty}), s_q.wdata, s_q.wstrb);
					s_d.duty = wv[1:0];
					s_d.bias_en = wv[4:2];
				end
				spm_pkg::A_STS:
				begin
					if (s_q.wstrb[0])
					begin
						clr = s_q.wdata[2:0];
					end
				end
				spm_pkg::A_MSK:
				begin
					if (s_q.wstrb[0])
					begin
						s_d.msk = s_q.wdata[2:0];
					end
				end
				spm_pkg::A_D_IN, spm_pkg::A_P_IN:
				begin
					s_d.bresp = spm_pkg::RESP_OK;
				end
				default:
				begin
					s_d.bresp = spm_pkg::RESP_SLVERR;
				end
			endcase
		end
		if (s_q.bvalid && s_axi_bready)
		begin
			s_d.bvalid = 1'b0;
			s_d.awready = 1'b1;
			s_d.wready = 1'b1;
		end

		// read channel, data one cycle after the address
		if (s_axi_arvalid && s_q.arready)
		begin
			s_d.arready = 1'b0;
			s_d.rvalid = 1'b1;
			s_d.rresp = spm_pkg::RESP_OK;
			case (s_axi_araddr)
				spm_pkg::A_D_LAT: s_d.rdata = 32'(s_q.d_lat);
				spm_pkg::A_D_CMOS: s_d.rdata = 32'(s_q.d_cmos);
				spm_pkg::A_D_IN: s_d.rdata = 32'(s_q.d_s);
				spm_pkg::A_SKIP: s_d.rdata = 32'({s_q.skip_idx, s_q.skip});
				spm_pkg::A_P_LAT: s_d.rdata = 32'(s_q.p_lat);
				spm_pkg::A_P_CMOS: s_d.rdata = 32'(s_q.p_cmos);
				// pin level is read whatever the latch; a low latch reads itself back
				spm_pkg::A_P_IN: s_d.rdata = 32'(s_q.p_s);
				spm_pkg::A_CFG: s_d.rdata = 32'(s_q.cfg);
				spm_pkg::A_SEGSEL: s_d.rdata = 32'(s_q.segsel);
				spm_pkg::A_LCD: s_d.rdata = 32'({s_q.bias_en, s_q.duty});
				spm_pkg::A_STS: s_d.rdata = 32'(s_q.sts);
				spm_pkg::A_MSK: s_d.rdata = 32'(s_q.msk);
				default:
				begin
					s_d.rdata = '0;
					s_d.rresp = spm_pkg::RESP_SLVERR;
				end
			endcase
		end
		if (s_q.rvalid && s_axi_rready)
		begin
			s_d.rvalid = 1'b0;
			s_d.arready = 1'b1;
		end

		// ========================================
		// events and interrupt
		wake_lvl = (s_q.cfg.kw_a && |(~s_q.p_s[3:0] & ~s_q.segsel[3:0]))
			|| (s_q.cfg.kw_b && |(~s_q.p_s[7:4] & ~s_q.segsel[7:4]))
			|| (s_q.cfg.int_kw && s_q.d_s[5]);
		rst_any = software_reset_instr || wdt_reset || por_reset || vdrop_reset;
		ev = '0;
		ev[spm_pkg::IRQ_INT] = s_q.cfg.int_en && s_q.d_s[5] && !s_q.d5_prev;
		ev[spm_pkg::IRQ_KEY] = wake_lvl && !s_q.wake;
		ev[spm_pkg::IRQ_RST] = rst_any && !s_q.rst_prev;
		s_d.d5_prev = s_q.d_s[5];
		s_d.wake = wake_lvl;
		s_d.rst_prev = rst_any;
		s_d.int_req = ev[spm_pkg::IRQ_INT];
		// a new event beats a same-cycle clear
		s_d.sts = (s_q.sts & ~clr) | ev;
		s_d.irq = |(s_d.sts & s_q.msk);

		// ========================================
		// bitwise port drive
		s_d.d_o = s_q.d_lat;
		s_d.d_oe[5:0] = s_q.d_cmos | ~s_q.d_lat[5:0];
		// top bits open-drain only, released while the oscillator owns them
		s_d.d_oe[7:6] = s_q.cfg.subclk_en ? 2'h0 : ~s_q.d_lat[7:6];
		s_d.osc_en = s_q.cfg.subclk_en;

		// ========================================
		// nibble ports and shared segments, order {c, b, a}
		pseg = {lcd_segment_outputs_shared[3:0], lcd_segment_outputs_shared[11:8],
			lcd_segment_outputs_shared[7:4]};
		for (int i = 0; i < 12; i++)
		begin
			if (s_q.segsel[i])
			begin
				s_d.p.o[i] = pseg[i];
				s_d.p.oe[i] = 1'b1;
			end
			else
			begin
				s_d.p.o[i] = s_q.p_lat[i];
				s_d.p.oe[i] = s_q.p_cmos[i] | ~s_q.p_lat[i];
			end
		end
		s_d.pu = {4'h0, {4{s_q.cfg.pu_b}}, {4{s_q.cfg.pu_a}}} & ~s_q.segsel;

		// ========================================
		// one-bit port and timer pin
		s_d.c_o = s_q.cfg.c_lat | (s_q.cfg.pwm_out && timer2_pwm);
		// counting from the pin turns the push-pull driver off
		s_d.c_oe = !s_q.cfg.cnt_in;
		s_d.cnt = s_q.cfg.cnt_in && s_q.c_s;

		// ========================================
		// lcd commons and bias pins
		case (s_q.duty)
			spm_pkg::DUTY_HALF: s_d.com = lcd_common_in & 4'h3;
			spm_pkg::DUTY_THIRD: s_d.com = lcd_common_in & 4'h7;
			default: s_d.com = lcd_common_in;
		endcase
		s_d.lo_o = lcd_segment_outputs_low;
		s_d.lo_oe = ~s_q.bias_en;
		s_d.bias_sel = s_q.bias_en;

		// ========================================
		// reset pin, open-drain low while any internal reset is asserted
		s_d.rst_oe = rst_any;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_q <= spm_pkg::ST_RST;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// ========================================
	// outputs
	assign s_axi_awready = s_q.awready;
	assign s_axi_wready = s_q.wready;
	assign s_axi_bresp = s_q.bresp;
	assign s_axi_bvalid = s_q.bvalid;
	assign s_axi_arready = s_q.arready;
	assign s_axi_rdata = s_q.rdata;
	assign s_axi_rresp = s_q.rresp;
	assign s_axi_rvalid = s_q.rvalid;
	assign bitwise_port_o = s_q.d_o;
	assign bitwise_port_oe = s_q.d_oe;
	assign subclk_osc_en = s_q.osc_en;
	assign nibble_ports_out = s_q.p;
	assign nibble_ports_pullup = s_q.pu;
	assign seg_low_o = s_q.lo_o;
	assign seg_low_oe = s_q.lo_oe;
	assign lcd_bias_supply_pins_sel = s_q.bias_sel;
	assign lcd_common_outputs = s_q.com;
	assign timer_io_pin_o = s_q.c_o;
	assign timer_io_pin_oe = s_q.c_oe;
	assign timer1_count_clk = s_q.cnt;
	assign ext_int_req = s_q.int_req;
	assign key_wakeup = s_q.wake;
	assign reset_pin_oe = s_q.rst_oe;
	assign irq = s_q.irq;
endmodule

/* File: spm_pkg.sv */
package spm_pkg;
	// ========================================
	// register byte offsets
	localparam logic [7:0] A_D_LAT = 8'h00;
	localparam logic [7:0] A_D_CMOS = 8'h04;
	localparam logic [7:0] A_D_IN = 8'h08;
	localparam logic [7:0] A_SKIP = 8'h0c;
	localparam logic [7:0] A_P_LAT = 8'h10;
	localparam logic [7:0] A_P_CMOS = 8'h14;
	localparam logic [7:0] A_P_IN = 8'h18;
	localparam logic [7:0] A_CFG = 8'h1c;
	localparam logic [7:0] A_SEGSEL = 8'h20;
	localparam logic [7:0] A_LCD = 8'h24;
	localparam logic [7:0] A_STS = 8'h28;
	localparam logic [7:0] A_MSK = 8'h2c;
	// ========================================
	// field positions and codes
	localparam int IRQ_INT = 0;
	localparam int IRQ_KEY = 1;
	localparam int IRQ_RST = 2;
	localparam int D_IO_BITS = 6;
	localparam logic [1:0] DUTY_HALF = 2'h0;
	localparam logic [1:0] DUTY_THIRD = 2'h1;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ========================================
	// reset values
	localparam logic [7:0] D_LAT_RST = 8'hff;
	localparam logic [11:0] P_LAT_RST = 12'hfff;
	localparam logic [1:0] DUTY_RST = 2'h2;
	// ========================================
	// carriers
	typedef struct packed {
		logic [11:0] o;
		logic [11:0] oe;
	} spm_pio_t;
	typedef struct packed {
		logic subclk_en;
		logic c_lat;
		logic pwm_out;
		logic cnt_in;
		logic int_en;
		logic int_kw;
		logic kw_b;
		logic kw_a;
		logic pu_b;
		logic pu_a;
	} spm_cfg_t;
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic aw_have;
		logic w_have;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic [7:0] d_lat;
		logic [5:0] d_cmos;
		logic [11:0] p_lat;
		logic [11:0] p_cmos;
		spm_cfg_t cfg;
		logic [11:0] segsel;
		logic [1:0] duty;
		logic [2:0] bias_en;
		logic [2:0] sts;
		logic [2:0] msk;
		logic [2:0] skip_idx;
		logic skip;
		logic [5:0] d_m;
		logic [5:0] d_s;
		logic [11:0] p_m;
		logic [11:0] p_s;
		logic c_m;
		logic c_s;
		logic d5_prev;
		logic wake;
		logic rst_prev;
		logic irq;
		logic int_req;
		logic [7:0] d_o;
		logic [7:0] d_oe;
		spm_pio_t p;
		logic [11:0] pu;
		logic c_o;
		logic c_oe;
		logic cnt;
		logic [3:0] com;
		logic [2:0] lo_o;
		logic [2:0] lo_oe;
		logic [2:0] bias_sel;
		logic rst_oe;
		logic osc_en;
	} spm_st_t;
	localparam spm_st_t ST_RST = '{awready: 1'b1, wready: 1'b1, arready: 1'b1,
		d_lat: D_LAT_RST, p_lat: P_LAT_RST, duty: DUTY_RST, default: '0};
endpackage

/* File: spm_mux_sva.sv */
`timescale 1ns/1ps
module spm_mux_sva (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic [7:0] bitwise_port_o,
	input wire logic [7:0] bitwise_port_oe,
	input wire logic subclk_osc_en,
	input wire logic [11:0] nibble_ports_pullup,
	input wire logic [2:0] seg_low_oe,
	input wire logic [2:0] lcd_bias_supply_pins_sel,
	input wire logic timer_io_pin_oe,
	input wire logic timer1_count_clk,
	input wire logic ext_int_req,
	input wire logic software_reset_instr,
	input wire logic wdt_reset,
	input wire logic por_reset,
	input wire logic vdrop_reset,
	input wire logic reset_pin_oe
);
	// ========================================
	// properties
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic rst_any;
	assign rst_any = software_reset_instr | wdt_reset | por_reset | vdrop_reset;
	sequence wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence b_next;
		!s_axi_bvalid ##1 s_axi_bvalid;
	endsequence
	a_wr_answer: assert property (wr_take |=> b_next) else $error("write answer late");
	a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_rst_pin_low: assert property (rst_any |=> reset_pin_oe)
		else $error("reset pin not driven");
	a_rst_pin_free: assert property (!rst_any |=> !reset_pin_oe)
		else $error("reset pin driven idle");
	a_xtal_od: assert property ((bitwise_port_oe[7:6] & bitwise_port_o[7:6]) == 2'h0)
		else $error("top bits drive high");
	a_xtal_float: assert property (subclk_osc_en && $past(subclk_osc_en) |->
		bitwise_port_oe[7:6] == 2'h0) else $error("top bits driven in osc mode");
	a_pull_c: assert property (nibble_ports_pullup[11:8] == 4'h0)
		else $error("port c pull-up on");
	a_bias_off: assert property (|lcd_bias_supply_pins_sel |->
		(seg_low_oe & lcd_bias_supply_pins_sel) == 3'h0) else $error("bias pin driven");
	a_cnt_dir: assert property (timer1_count_clk |-> !timer_io_pin_oe)
		else $error("timer pin driven while counting");
	a_int_pulse: assert property (ext_int_req |=> !ext_int_req)
		else $error("interrupt request too long");
endmodule
bind spm_shared_pin_port_mux spm_mux_sva spm_mux_sva_inst (.aclk, .aresetn, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .bitwise_port_o, .bitwise_port_oe, .subclk_osc_en,
	.nibble_ports_pullup, .seg_low_oe, .lcd_bias_supply_pins_sel, .timer_io_pin_oe,
	.timer1_count_clk, .ext_int_req, .software_reset_instr, .wdt_reset, .por_reset,
	.vdrop_reset, .reset_pin_oe);

/* File: spm_pins.sv */
`timescale 1ns/1ps
module spm_pins (
	input wire logic [7:0] d_o,
	input wire logic [7:0] d_oe,
	input wire logic [5:0] d_ext,
	input wire spm_pkg::spm_pio_t n_io,
	input wire logic [11:0] n_pu,
	input wire logic [11:0] n_ext,
	input wire logic c_o,
	input wire logic c_oe,
	input wire logic c_ext,
	output logic [5:0] d_pin,
	output logic [11:0] n_pin,
	output logic c_pin
);
	// ========================================
	// pad levels: driver wins, else pull-up, else key level
	always_comb
	begin
		for (int i = 0; i < 6; i++)
			d_pin[i] = d_oe[i] ? d_o[i] : d_ext[i];
		for (int i = 0; i < 12; i++)
			n_pin[i] = n_io.oe[i] ? n_io.o[i] : (n_pu[i] | n_ext[i]);
		c_pin = c_oe ? c_o : c_ext;
	end
endmodule

/* File: spm_shared_pin_port_mux_test.sv */
`timescale 1ns/1ps
module spm_shared_pin_port_mux_test;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr, bitwise_port_o, bitwise_port_oe;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [5:0] d_pin, d_ext;
	logic [11:0] n_pin, n_ext, nibble_ports_pullup, seg_sh;
	spm_pkg::spm_pio_t nibble_ports_out;
	logic [2:0] seg_lo, seg_low_o, seg_low_oe, lcd_bias_supply_pins_sel;
	logic [3:0] com_in, lcd_common_outputs, rsrc;
	logic c_pin, c_ext, timer_io_pin_o, timer_io_pin_oe, pwm, timer1_count_clk;
	logic subclk_osc_en, ext_int_req, key_wakeup, reset_pin_oe, irq, int_seen;
	int error_cnt, num_checks;
	spm_shared_pin_port_mux spm_shared_pin_port_mux_inst (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .bitwise_port_io_bits_i(d_pin), .bitwise_port_o, .bitwise_port_oe,
		.subclk_osc_en, .nibble_ports_i(n_pin), .nibble_ports_out, .nibble_ports_pullup,
		.lcd_segment_outputs_shared(seg_sh), .lcd_segment_outputs_low(seg_lo), .seg_low_o,
		.seg_low_oe, .lcd_bias_supply_pins_sel, .lcd_common_in(com_in), .lcd_common_outputs,
		.timer_io_pin_i(c_pin), .timer_io_pin_o, .timer_io_pin_oe, .timer2_pwm(pwm),
		.timer1_count_clk, .ext_int_req, .key_wakeup, .software_reset_instr(rsrc[0]),
		.wdt_reset(rsrc[1]), .por_reset(rsrc[2]), .vdrop_reset(rsrc[3]), .reset_pin_oe, .irq);
	spm_pins spm_pins_inst (.d_o(bitwise_port_o), .d_oe(bitwise_port_oe), .d_ext,
		.n_io(nibble_ports_out), .n_pu(nibble_ports_pullup), .n_ext, .c_o(timer_io_pin_o),
		.c_oe(timer_io_pin_oe), .c_ext, .d_pin, .n_pin, .c_pin);
	// ========================================
	// helpers
	initial
	begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end
	always @(posedge aclk)
		if (ext_int_req)
			int_seen <= 1'b1;
	task automatic end_sim();
		if (error_cnt == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e)
		begin
			$display("wrong value %s expected %h seen %h", nm, e, g);
			error_cnt++;
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge aclk);
	endtask
	// no fixed latency assumed: loop until the answer, bounded
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		n = 0;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
			n++;
		end
		while (!s_axi_bvalid && n < 99);
		// a write that never answers counts against the run
		if (!s_axi_bvalid)
			error_cnt++;
		s_axi_bready <= 1'b0;
		chk("bresp", 32'(er), 32'(s_axi_bresp));
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		int n;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		n = 0;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
			n++;
		end
		while (!s_axi_rvalid && n < 99);
		if (!s_axi_rvalid)
			error_cnt++;
		s_axi_rready <= 1'b0;
		chk("rresp", 32'(er), 32'(s_axi_rresp));
		chk("rdata", e, s_axi_rdata);
	endtask
	// ========================================
	// scenarios
	task automatic t_regs();
		rd(spm_pkg::A_D_LAT, 32'hff, spm_pkg::RESP_OK);
		rd(spm_pkg::A_P_LAT, 32'hfff, spm_pkg::RESP_OK);
		rd(spm_pkg::A_LCD, 32'h2, spm_pkg::RESP_OK);
		rd(8'h40, 32'h0, spm_pkg::RESP_SLVERR);
		wr(8'h40, 32'h1, spm_pkg::RESP_SLVERR);
	endtask
	task automatic t_dport();
		wr(spm_pkg::A_D_LAT, 32'h96, spm_pkg::RESP_OK);
		wt(4);
		chk("d_oe", 32'h69, 32'(bitwise_port_oe));
		rd(spm_pkg::A_D_IN, 32'h16, spm_pkg::RESP_OK);
		d_ext <= 6'h00;
		wr(spm_pkg::A_D_CMOS, 32'h3f, spm_pkg::RESP_OK);
		wt(4);
		rd(spm_pkg::A_D_IN, 32'h16, spm_pkg::RESP_OK);
		wr(spm_pkg::A_D_CMOS, 32'h0, spm_pkg::RESP_OK);
		wr(spm_pkg::A_D_LAT, 32'hff, spm_pkg::RESP_OK);
		d_ext <= 6'h37;
		wt(4);
		wr(spm_pkg::A_SKIP, 32'h3, spm_pkg::RESP_OK);
		rd(spm_pkg::A_SKIP, 32'h7, spm_pkg::RESP_OK);
		wr(spm_pkg::A_SKIP, 32'h2, spm_pkg::RESP_OK);
		rd(spm_pkg::A_SKIP, 32'h4, spm_pkg::RESP_OK);
		wr(spm_pkg::A_D_LAT, 32'h3f, spm_pkg::RESP_OK);
		wt(2);
		chk("d_top_oe", 32'h3, 32'(bitwise_port_oe[7:6]));
		wr(spm_pkg::A_CFG, 32'h200, spm_pkg::RESP_OK);
		wt(2);
		chk("osc_top_oe", 32'h4, {29'h0, subclk_osc_en, bitwise_port_oe[7:6]});
		wr(spm_pkg::A_D_LAT, 32'hdf, spm_pkg::RESP_OK);
		wr(spm_pkg::A_CFG, 32'h20, spm_pkg::RESP_OK);
		wt(2);
		chk("d5_oe", 32'h1, 32'(bitwise_port_oe[5]));
		wr(spm_pkg::A_D_LAT, 32'hff, spm_pkg::RESP_OK);
	endtask
	task automatic t_nib();
		wr(spm_pkg::A_SEGSEL, 32'hfff, spm_pkg::RESP_OK);
		wr(spm_pkg::A_CFG, 32'h3, spm_pkg::RESP_OK);
		wt(2);
		chk("n_out", 32'h35afff, 32'(nibble_ports_out));
		chk("pu_seg", 32'h0, 32'(nibble_ports_pullup));
		wr(spm_pkg::A_SEGSEL, 32'h0, spm_pkg::RESP_OK);
		wr(spm_pkg::A_P_LAT, 32'h0f0, spm_pkg::RESP_OK);
		wt(4);
		chk("pu", 32'h0ff, 32'(nibble_ports_pullup));
		chk("n_oe", 32'hf0f, 32'(nibble_ports_out.oe));
		rd(spm_pkg::A_P_IN, 32'h0f0, spm_pkg::RESP_OK);
		wr(spm_pkg::A_P_LAT, 32'hfff, spm_pkg::RESP_OK);
		n_ext <= 12'hffe;
		wr(spm_pkg::A_CFG, 32'h4, spm_pkg::RESP_OK);
		wt(4);
		chk("wake", 32'h1, 32'(key_wakeup));
		n_ext <= 12'hfef;
		wr(spm_pkg::A_CFG, 32'h8, spm_pkg::RESP_OK);
		wt(4);
		chk("wake_b", 32'h1, 32'(key_wakeup));
		n_ext <= 12'hfff;
		wr(spm_pkg::A_CFG, 32'h10, spm_pkg::RESP_OK);
		wt(4);
		chk("wake_int", 32'h1, 32'(key_wakeup));
	endtask
	task automatic t_timer();
		wr(spm_pkg::A_CFG, 32'h180, spm_pkg::RESP_OK);
		wt(2);
		chk("c_drive", 32'h3, {30'h0, timer_io_pin_o, timer_io_pin_oe});
		wr(spm_pkg::A_CFG, 32'h80, spm_pkg::RESP_OK);
		pwm <= 1'b1;
		wt(3);
		chk("pwm_hi", 32'h1, 32'(timer_io_pin_o));
		pwm <= 1'b0;
		wt(3);
		chk("pwm_lo", 32'h0, 32'(timer_io_pin_o));
		c_ext <= 1'b1;
		wr(spm_pkg::A_CFG, 32'h40, spm_pkg::RESP_OK);
		wt(5);
		chk("cnt", 32'h1, {30'h0, timer_io_pin_oe, timer1_count_clk});
	endtask
	task automatic t_lcd();
		logic [3:0] exp_com[4] = '{4'h3, 4'h7, 4'hf, 4'hf};
		for (int k = 0; k < 4; k++)
		begin
			wr(spm_pkg::A_LCD, 32'(k), spm_pkg::RESP_OK);
			wt(3);
			chk("com", 32'(exp_com[k]), 32'(lcd_common_outputs));
		end
		wr(spm_pkg::A_LCD, 32'h16, spm_pkg::RESP_OK);
		wt(3);
		chk("bias", 32'h2a, {26'h0, lcd_bias_supply_pins_sel, seg_low_oe});
		chk("seg_lo", 32'h5, 32'(seg_low_o));
	endtask
	task automatic t_int();
		d_ext <= 6'h1f;
		wr(spm_pkg::A_CFG, 32'h20, spm_pkg::RESP_OK);
		wr(spm_pkg::A_STS, 32'h7, spm_pkg::RESP_OK);
		wr(spm_pkg::A_MSK, 32'h7, spm_pkg::RESP_OK);
		int_seen <= 1'b0;
		d_ext <= 6'h3f;
		wt(6);
		chk("int_req", 32'h3, {30'h0, int_seen, irq});
		rd(spm_pkg::A_STS, 32'h1, spm_pkg::RESP_OK);
		wr(spm_pkg::A_STS, 32'h1, spm_pkg::RESP_OK);
		wt(2);
		chk("irq_clr", 32'h0, 32'(irq));
		for (int i = 0; i < 4; i++)
		begin
			rsrc <= 4'h1 << i;
			wt(2);
			chk("rst_pin", 32'h1, 32'(reset_pin_oe));
			rsrc <= 4'h0;
			wt(2);
			chk("rst_free", 32'h0, 32'(reset_pin_oe));
		end
		rd(spm_pkg::A_STS, 32'h4, spm_pkg::RESP_OK);
	endtask
	initial
	begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, pwm, c_ext, rsrc} = '0;
		{error_cnt, num_checks, int_seen} = '0;
		d_ext = 6'h3f;
		n_ext = 12'hfff;
		seg_sh = 12'h5a3;
		seg_lo = 3'h5;
		com_in = 4'hf;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_dport();
		t_nib();
		t_timer();
		t_lcd();
		t_int();
		end_sim();
	end
	initial
	begin
		#400000;
		error_cnt++;
		end_sim();
	end
endmodule
